// File: src/epa_pkg.sv
package epa_pkg;
   localparam int unsigned ADDR_W = 24;
   localparam int unsigned OFS_W = 10;
   localparam logic [1:0] TRACE_MODE = 2'h2;

   typedef enum logic [2:0] {
      EPA_SRC_NONE,
      EPA_SRC_RESET,
      EPA_SRC_ILLEGAL,
      EPA_SRC_TRACE,
      EPA_SRC_ADDR_ERR,
      EPA_SRC_INTERRUPT,
      EPA_SRC_TRAP
   } epa_src_t;

   // vector table offsets, advanced mode
   localparam logic [OFS_W-1:0] OFS_RESET = 10'h000;
   localparam logic [OFS_W-1:0] OFS_ILLEGAL = 10'h010;
   localparam logic [OFS_W-1:0] OFS_TRACE = 10'h014;
   localparam logic [OFS_W-1:0] OFS_TRAP0 = 10'h020;
   localparam logic [OFS_W-1:0] OFS_ADDR_ERR = 10'h030;

   // per-boundary information from the sequencer
   typedef struct packed {
      logic inst_done;
      logic exc_done;
      logic was_exc_return;
      logic was_ccr_or_ctl_load;
      logic was_reset_exc;
   } epa_bnd_t;

   typedef struct packed {
      logic valid;
      epa_src_t src;
      logic [ADDR_W-1:0] vec_addr;
   } epa_sel_t;
endpackage

// File: src/epa_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module epa_arbiter
   import epa_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // reset sources
   input wire logic reset_input_pin_n,
   input wire logic wdt_overflow,
   // requests
   input wire logic undef_opcode,
   input wire logic addr_err,
   input wire logic irq_req,
   input wire logic [OFS_W-1:0] irq_vec_ofs,
   input wire logic trap_always_instr,
   input wire logic [1:0] trap_num,
   // context
   input wire epa_bnd_t bnd,
   input wire logic trace_flag,
   input wire logic [1:0] int_ctrl_mode,
   input wire logic [ADDR_W-1:0] vector_base_reg,
   input wire logic sel_ack,
   // to sequencer
   output epa_sel_t sel,
   output logic in_reset
);
   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   logic [2:0] pin_q, pin_d;
   logic pin_st_q, pin_st_d;
   always_comb begin
      pin_d = {pin_q[1:0], reset_input_pin_n};
      pin_st_d = (pin_q[1] == pin_q[2]) ? pin_q[2] : pin_st_q;
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_q <= 3'h0;
         pin_st_q <= 1'h0;
      end else begin
         pin_q <= pin_d;
         pin_st_q <= pin_st_d;
      end
   end
   // a level counts only once two stages agree, so a glitch cannot start reset
   wire logic pin_rise = pin_st_d & ~pin_st_q;

   // ---------------------------------------------------------------
   // pending latches
   // ---------------------------------------------------------------
   logic rst_p_q, ill_p_q, trc_p_q, adr_p_q, adr_seen_q, trp_p_q;
   logic rst_p_d, ill_p_d, trc_p_d, adr_p_d, adr_seen_d, trp_p_d;
   logic [1:0] trp_n_q, trp_n_d;
   logic in_reset_q, in_reset_d;
   epa_sel_t sel_q, sel_d;
   logic boundary, irq_ok, trace_ok, adr_set;
   epa_src_t win;

   function automatic logic [ADDR_W-1:0] vec_of(input epa_src_t s, input logic [OFS_W-1:0] o,
                                                 input logic [ADDR_W-1:0] base);
      if (s == EPA_SRC_RESET || s == EPA_SRC_ADDR_ERR)
         vec_of = {{(ADDR_W-OFS_W){1'h0}}, o};
      else
         vec_of = base + {{(ADDR_W-OFS_W){1'h0}}, o};
   endfunction

   always_comb begin
      boundary = bnd.inst_done | bnd.exc_done;
      irq_ok = boundary & irq_req & ~bnd.was_ccr_or_ctl_load & ~bnd.was_reset_exc;
      trace_ok = boundary & trace_flag & (int_ctrl_mode == TRACE_MODE) & ~bnd.was_exc_return;
      in_reset_d = ~pin_st_d ? 1'h1 : (pin_rise ? 1'h0 : in_reset_q);
      // set wins over the acceptance clear
      rst_p_d = rst_p_q | pin_rise | wdt_overflow;
      ill_p_d = ill_p_q | (undef_opcode & ~in_reset_q);
      trc_p_d = trc_p_q | trace_ok;
      adr_set = (adr_seen_q | addr_err) & bnd.inst_done;
      adr_seen_d = (adr_seen_q | addr_err) & ~bnd.inst_done;
      adr_p_d = adr_p_q | adr_set;
      trp_p_d = trp_p_q | (trap_always_instr & ~in_reset_q);
      trp_n_d = trap_always_instr ? trap_num : trp_n_q;
      sel_d = sel_q;
      win = EPA_SRC_NONE;
      if (rst_p_q) win = EPA_SRC_RESET;
      else if (ill_p_q) win = EPA_SRC_ILLEGAL;
      else if (trc_p_q) win = EPA_SRC_TRACE;
      else if (adr_p_q) win = EPA_SRC_ADDR_ERR;
      // a trace or address error latched at this same boundary outranks it
      else if (irq_ok & ~trace_ok & ~adr_set) win = EPA_SRC_INTERRUPT;
      else if (trp_p_q) win = EPA_SRC_TRAP;
      if (sel_q.valid & sel_ack) sel_d.valid = 1'h0;
      if (~pin_st_d) begin
         sel_d = '0;
         ill_p_d = 1'h0;
         trc_p_d = 1'h0;
         adr_p_d = 1'h0;
         trp_p_d = 1'h0;
      end else if (~sel_d.valid & win != EPA_SRC_NONE) begin
         sel_d.valid = 1'h1;
         sel_d.src = win;
         case (win)
            EPA_SRC_RESET: begin
               sel_d.vec_addr = vec_of(win, OFS_RESET, vector_base_reg);
               rst_p_d = pin_rise | wdt_overflow;
            end
            EPA_SRC_ILLEGAL: begin
               sel_d.vec_addr = vec_of(win, OFS_ILLEGAL, vector_base_reg);
               ill_p_d = undef_opcode;
            end
            EPA_SRC_TRACE: begin
               sel_d.vec_addr = vec_of(win, OFS_TRACE, vector_base_reg);
               trc_p_d = trace_ok;
            end
            EPA_SRC_ADDR_ERR: begin
               sel_d.vec_addr = vec_of(win, OFS_ADDR_ERR, vector_base_reg);
               adr_p_d = adr_set;
            end
            EPA_SRC_INTERRUPT: begin
               sel_d.vec_addr = vec_of(win, irq_vec_ofs, vector_base_reg);
            end
            EPA_SRC_TRAP: begin
               sel_d.vec_addr = vec_of(win, OFS_TRAP0 + {6'h00, trp_n_q, 2'h0}, vector_base_reg);
               trp_p_d = trap_always_instr;
            end
            default: sel_d.valid = 1'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rst_p_q <= 1'h0;
         ill_p_q <= 1'h0;
         trc_p_q <= 1'h0;
         adr_p_q <= 1'h0;
         adr_seen_q <= 1'h0;
         trp_p_q <= 1'h0;
         trp_n_q <= 2'h0;
         in_reset_q <= 1'h1;
         sel_q <= '0;
      end else begin
         rst_p_q <= rst_p_d;
         ill_p_q <= ill_p_d;
         trc_p_q <= trc_p_d;
         adr_p_q <= adr_p_d;
         adr_seen_q <= adr_seen_d;
         trp_p_q <= trp_p_d;
         trp_n_q <= trp_n_d;
         in_reset_q <= in_reset_d;
         sel_q <= sel_d;
      end
   end

   assign sel = sel_q;
   assign in_reset = in_reset_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_reset_first;
      @(posedge clk_sys) disable iff (rst)
      (rst_p_q & pin_st_d & ~sel_q.valid) |=> (sel_q.valid && sel_q.src == EPA_SRC_RESET);
   endproperty
   a_reset_first: assert property (p_reset_first) else $error("reset not served first");

   property p_one_at_time;
      @(posedge clk_sys) disable iff (rst)
      // a low pin drops the selection at once
      (sel_q.valid & ~sel_ack & pin_st_d) |=> ($stable(sel_q.src) && sel_q.valid);
   endproperty
   a_one_at_time: assert property (p_one_at_time) else $error("selection changed before ack");

   property p_pin_rise;
      @(posedge clk_sys) disable iff (rst) pin_rise |=> rst_p_q;
   endproperty
   a_pin_rise: assert property (p_pin_rise) else $error("pin rise missed");

   sequence s_pin_low;
      ~pin_st_q [*2];
   endsequence
   property p_hold_reset;
      @(posedge clk_sys) disable iff (rst) s_pin_low |-> (in_reset_q && !sel_q.valid);
   endproperty
   a_hold_reset: assert property (p_hold_reset) else $error("activity during reset");

   property p_illegal;
      @(posedge clk_sys) disable iff (rst)
      (undef_opcode & ~in_reset_q & pin_st_d) |=> ill_p_q;
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal request lost");

   property p_trace_mode;
      @(posedge clk_sys) disable iff (rst)
      (!trc_p_q && (int_ctrl_mode != TRACE_MODE || bnd.was_exc_return)) |=> !trc_p_q;
   endproperty
   a_trace_mode: assert property (p_trace_mode) else $error("trace latched outside mode 2 or after return");

   property p_irq_boundary;
      @(posedge clk_sys) disable iff (rst)
      (sel_d.valid && !sel_q.valid && sel_d.src == EPA_SRC_INTERRUPT) |->
         (boundary && !bnd.was_ccr_or_ctl_load && !bnd.was_reset_exc);
   endproperty
   a_irq_boundary: assert property (p_irq_boundary) else $error("interrupt off boundary");

   property p_addr_wait;
      @(posedge clk_sys) disable iff (rst)
      (addr_err & ~bnd.inst_done & ~adr_seen_q & ~adr_p_q) |=> !adr_p_q;
   endproperty
   a_addr_wait: assert property (p_addr_wait) else $error("address error not postponed");

   property p_vec;
      @(posedge clk_sys) disable iff (rst)
      (sel_q.valid && sel_q.src == EPA_SRC_ADDR_ERR) |-> sel_q.vec_addr == {{(ADDR_W-OFS_W){1'h0}}, OFS_ADDR_ERR};
   endproperty
   a_vec: assert property (p_vec) else $error("address error vector wrong");

   property p_irq_yields;
      @(posedge clk_sys) disable iff (rst)
      (irq_ok & (trace_ok | adr_set) & ~sel_q.valid) |=> !(sel_q.valid && sel_q.src == EPA_SRC_INTERRUPT);
   endproperty
   a_irq_yields: assert property (p_irq_yields) else $error("interrupt ahead of trace or address error");
endmodule
`default_nettype wire

// File: verification/epa_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module epa_seq_model
   import epa_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // selection handshake
   input wire epa_sel_t sel,
   input wire logic [3:0] dly,
   output logic sel_ack,
   // end of handling, log of takes
   output logic done,
   output epa_sel_t taken,
   output int n_taken
);
   logic [3:0] wt = 4'h0;
   logic [1:0] dq = 2'h0;
   initial begin
      sel_ack = 1'h0;
      done = 1'h0;
      taken = '0;
      n_taken = 0;
   end
   // handling ends two cycles after the take, so boundaries trail the ack
   always @(posedge clk_sys) begin
      done <= dq == 2'h1;
      dq <= dq - 2'(dq != 2'h0);
      sel_ack <= 1'h0;
      wt <= 4'h0;
      if (sel.valid && !sel_ack) begin
         wt <= wt + 4'h1;
         if (wt == dly) begin
            sel_ack <= 1'h1;
            taken <= sel;
            n_taken <= n_taken + 1;
            dq <= 2'h2;
         end
      end
   end
endmodule
`default_nettype wire

// File: verification/exception_priority_arbiter_test.sv
`timescale 1ns/1ps
`default_nettype none
module exception_priority_arbiter_test
   import epa_pkg::*;
;
   localparam logic [ADDR_W-1:0] VEC_BASE = 24'h123400;
   logic clk_sys = 1'h0, rst = 1'h1, pin = 1'h0, wdt = 1'h0, und = 1'h0, aerr = 1'h0, irq = 1'h0, trap = 1'h0;
   logic trc = 1'h0, ack, done, in_reset;
   logic [1:0] tn = 2'h0, mode = 2'h2;
   logic [3:0] dly = 4'h0;
   epa_bnd_t tb_bnd = '0;
   epa_bnd_t bnd;
   epa_sel_t sel, taken;
   int n_taken, n_mismatch = 0, compares = 0;
   always #2 clk_sys = ~clk_sys;
   // the end of reset handling is flagged as such
   assign bnd = tb_bnd | {1'h0, done, 2'h0, done && taken.src == EPA_SRC_RESET};
   epa_arbiter DUT (.clk_sys(clk_sys), .rst(rst), .reset_input_pin_n(pin), .wdt_overflow(wdt),
      .undef_opcode(und), .addr_err(aerr), .irq_req(irq), .irq_vec_ofs(10'h100), .trap_always_instr(trap),
      .trap_num(tn), .bnd(bnd), .trace_flag(trc), .int_ctrl_mode(mode), .vector_base_reg(VEC_BASE),
      .sel_ack(ack), .sel(sel), .in_reset(in_reset));
   epa_seq_model seq (.clk_sys(clk_sys), .sel(sel), .dly(dly), .sel_ack(ack), .done(done),
      .taken(taken), .n_taken(n_taken));
   task automatic chk(input string what, input logic [ADDR_W-1:0] exp, got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic take(input epa_src_t s, input logic [ADDR_W-1:0] v);
      int n0;
      n0 = n_taken;
      for (int k = 0; k < 60 && n_taken == n0; k++) tick(1);
      chk("count", ADDR_W'(n0 + 1), ADDR_W'(n_taken));
      chk("source", ADDR_W'(s), ADDR_W'(taken.src));
      chk("vector", v, taken.vec_addr);
   endtask
   task automatic none(input int n);
      int n0;
      n0 = n_taken;
      tick(n);
      chk("count", ADDR_W'(n0), ADDR_W'(n_taken));
   endtask
   task automatic bp(input logic [4:0] b);
      @(posedge clk_sys);
      tb_bnd <= epa_bnd_t'(b);
      @(posedge clk_sys);
      tb_bnd <= '0;
   endtask
   task automatic t_reset_irq;
      @(posedge clk_sys);
      irq <= 1'h1;
      pin <= 1'h1;
      take(EPA_SRC_RESET, 24'h000000);
      chk("in_reset", 24'h000000, ADDR_W'(in_reset));
      none(10);
      bp(5'h12);
      none(8);
      bp(5'h10);
      take(EPA_SRC_INTERRUPT, VEC_BASE + 24'h000100);
      @(posedge clk_sys);
      irq <= 1'h0;
   endtask
   task automatic t_trace;
      // the boundary that ends interrupt handling must pass before tracing is on
      none(4);
      @(posedge clk_sys);
      trc <= 1'h1;
      bp(5'h14);
      none(8);
      @(posedge clk_sys);
      mode <= 2'h0;
      bp(5'h10);
      none(8);
      @(posedge clk_sys);
      mode <= 2'h2;
      bp(5'h10);
      take(EPA_SRC_TRACE, VEC_BASE + 24'h000014);
      @(posedge clk_sys);
      trc <= 1'h0;
   endtask
   task automatic t_mix;
      @(posedge clk_sys);
      {und, aerr, trap} <= 3'h7;
      tn <= 2'h1;
      @(posedge clk_sys);
      {und, aerr, trap} <= 3'h0;
      take(EPA_SRC_ILLEGAL, VEC_BASE + 24'h000010);
      take(EPA_SRC_TRAP, VEC_BASE + 24'h000024);
      none(8);
      @(posedge clk_sys);
      trc <= 1'h1;
      irq <= 1'h1;
      bp(5'h10);
      take(EPA_SRC_TRACE, VEC_BASE + 24'h000014);
      @(posedge clk_sys);
      trc <= 1'h0;
      take(EPA_SRC_ADDR_ERR, 24'h000030);
      // controller drops the request as it is selected, before the next boundary
      @(posedge clk_sys);
      irq <= 1'h0;
      take(EPA_SRC_INTERRUPT, VEC_BASE + 24'h000100);
   endtask
   task automatic t_traps;
      dly <= 4'h3;
      for (int n = 0; n < 4; n++) begin
         @(posedge clk_sys);
         trap <= 1'h1;
         tn <= 2'(n);
         @(posedge clk_sys);
         trap <= 1'h0;
         take(EPA_SRC_TRAP, VEC_BASE + 24'h000020 + ADDR_W'(4 * n));
      end
   endtask
   task automatic t_wdt_pin;
      @(posedge clk_sys);
      wdt <= 1'h1;
      @(posedge clk_sys);
      wdt <= 1'h0;
      take(EPA_SRC_RESET, 24'h000000);
      dly <= 4'hF;
      @(posedge clk_sys);
      und <= 1'h1;
      @(posedge clk_sys);
      und <= 1'h0;
      pin <= 1'h0;
      none(8);
      chk("in_reset", 24'h000001, ADDR_W'(in_reset));
      chk("valid", 24'h000000, ADDR_W'(sel.valid));
      @(posedge clk_sys);
      pin <= 1'h1;
      take(EPA_SRC_RESET, 24'h000000);
      none(24);
   endtask
   task automatic end_of_test;
      if (n_mismatch == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'h0;
      none(4);
      chk("in_reset", 24'h000001, ADDR_W'(in_reset));
      t_reset_irq();
      t_trace();
      t_mix();
      t_traps();
      t_wdt_pin();
      end_of_test();
   end
endmodule
`default_nettype wire
